// ==== include/dps_pkg.sv ====
// Constants and carrier types for the drive parameter and status bank.
`default_nettype none
package dps_pkg;
   localparam int DPS_DW = 16;
   localparam int DPS_CW = 7;
   localparam logic [15:0] DPS_CNT_MAX = 16'h270f;
   // Monitor and parameter codes, used as register addresses.
   localparam logic [6:0] C_FW_SUFFIX = 7'h00;
   localparam logic [6:0] C_FEEDBACK = 7'h2b;
   localparam logic [6:0] C_RAMPED = 7'h2e;
   localparam logic [6:0] C_PULSE_ERR = 7'h31;
   localparam logic [6:0] C_AIN_RAW = 7'h37;
   localparam logic [6:0] C_AIN_ADJ = 7'h38;
   localparam logic [6:0] C_LINE_DIP = 7'h39;
   localparam logic [6:0] C_SER_ERR = 7'h3a;
   localparam logic [6:0] C_FREQ_OVF = 7'h3b;
   localparam logic [6:0] C_SCALE_PRI = 7'h3d;
   localparam logic [6:0] C_SCALE_SEC = 7'h3e;
   localparam logic [6:0] C_DISP_PRI = 7'h3f;
   localparam logic [6:0] C_DISP_SEC = 7'h40;
   localparam logic [6:0] C_GAIN = 7'h41;
   localparam logic [6:0] C_RESET = 7'h42;
   localparam logic [6:0] C_RATE = 7'h43;
   localparam logic [6:0] C_TRIM = 7'h44;
   localparam logic [6:0] C_RATE_THR = 7'h45;
   localparam logic [6:0] C_STATION = 7'h46;
   localparam logic [6:0] C_BAUD = 7'h47;
   localparam logic [6:0] C_FORMAT = 7'h48;
   localparam logic [6:0] C_CTL_MASK = 7'h49;
   localparam logic [6:0] C_ZS_LOGIC = 7'h4a;
   localparam logic [6:0] C_SP_MASK = 7'h4f;
   localparam logic [6:0] C_AOUT_SEL = 7'h50;
   localparam logic [6:0] C_AOUT_FS = 7'h51;
   localparam logic [6:0] C_AIN_SEL = 7'h54;
   localparam logic [6:0] C_AIN_ZERO = 7'h55;
   localparam logic [6:0] C_AIN_SPAN = 7'h56;
   localparam logic [6:0] C_FW_REV = 7'h63;
   // Serial error weights.
   localparam logic [5:0] SE_RANGE = 6'h20;
   localparam logic [5:0] SE_CODE = 6'h10;
   localparam logic [5:0] SE_FORMAT = 6'h08;
   localparam logic [5:0] SE_DATA = 6'h04;
   localparam logic [5:0] SE_PARITY = 6'h02;
   localparam logic [5:0] SE_LOCAL = 6'h01;
   localparam logic [5:0] STATION_ALL = 6'h00;
   localparam int BAUD_RATE [6] = '{300, 600, 1200, 2400, 4800, 9600};
   localparam logic [11:0] AOUT_FULL = 12'hfff;
   localparam int AIN_FILT_SHIFT = 3;
   localparam int AIN_SPAN_SHIFT = 11;
   localparam logic [15:0] TRIM_FULL = 16'h0064;
   // Firmware identity readouts; values are arbitrary.
   localparam logic [15:0] FW_SUFFIX_VAL = 16'h0042;
   localparam logic [15:0] FW_REV_VAL = 16'h0001;

   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] station;
      logic [6:0] code;
      logic [15:0] data;
      logic [5:0] link_err;
   } dps_msg_t;

   typedef struct packed {
      logic eight_bits;
      logic even_parity;
      logic two_stops;
   } dps_frame_t;
endpackage : dps_pkg
`default_nettype wire

// ==== logic/dps_bank.sv ====
// Drive parameter and status bank with serial message handling and derived outputs.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1 - count line dips, clear key zeroes
// RULE2 - count frequency overflows, clear key zeroes
// RULE3 - serial error code is weighted bit sum
// RULE4 - error code follows latest received message
// RULE5 - scaling mode per switch-selected primary/secondary
// RULE6 - display mode per switch-selected primary/secondary
// RULE7 - PID setting zero removes that term
// RULE8 - derivative acts only above rate threshold; code also acts when diff_error equals the threshold
// RULE9 - trim authority splits PID versus feedforward
// RULE10 - station address 1..32, own address accepted
// RULE11 - station zero accepted by every unit
// RULE12 - baud code 1..6 selects 300..9600
// RULE13 - format code selects data, parity, stops
// RULE14 - control mask hands switches to host
// RULE15 - zero-speed mode 0 follows ramped reference
// RULE16 - zero-speed mode 1 waits for feedback
// RULE17 - lockout setpoint mask gates setpoint editing
// RULE18 - analog output shows the selected code
// RULE19 - full-scale value sets proportional analog output
// RULE20 - analog input select decodes replacement target
// RULE21 - analog input reported raw and adjusted
// RULE22 - report firmware suffix and revision
// RULE23 - pulse error cleared on entering stop
// RULE24 - event counters saturate, never wrap
// RULE25 - out-of-range writes rejected, range bit set
module dps_bank import dps_pkg::*; #(
   parameter int CLK_HZ = 50000000
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [6:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire dps_msg_t msg,
   input wire logic computer_mode,
   input wire logic secondary_sel,
   input wire logic line_dip,
   input wire logic freq_overflow,
   input wire logic clear_key,
   input wire logic [6:0] keypad_code,
   input wire logic [15:0] ramped_reference,
   input wire logic [15:0] feedback_frequency,
   input wire logic ref_pulse,
   input wire logic fb_pulse,
   input wire logic stop_state,
   input wire logic [15:0] diff_error,
   input wire logic [7:0] switch_ctl,
   input wire logic [7:0] host_ctl,
   input wire logic keypad_lockout,
   input wire logic [11:0] ain_sample,
   output logic msg_accept,
   output logic [1:0] scale_mode,
   output logic [1:0] display_mode,
   output logic [2:0] pid_term_en,
   output logic rate_active,
   output logic [6:0] pid_share,
   output logic [6:0] ff_share,
   output logic bit_tick,
   output dps_frame_t frame,
   output logic [7:0] ctl_effective,
   output logic zero_speed,
   output logic [3:0] setpoint_edit_en,
   output logic [11:0] aout_level,
   output logic [6:0] ain_replace
);
   logic [15:0] param_mem [0:127];
   logic [15:0] line_dip_counter_reg;
   logic [15:0] freq_overflow_counter_reg;
   logic [5:0] serial_error_code_reg;
   logic signed [15:0] pulse_err_reg;
   logic stop_prev_reg;
   logic [11:0] ain_filt_reg;
   logic [11:0] ain_adj_reg;
   logic [17:0] baud_cnt_reg;
   logic [17:0] baud_div_next;
   logic addressed;
   logic msg_range_ok;
   logic [5:0] msg_err_next;

   function automatic logic is_param(input logic [6:0] c);
      return (c >= 7'h01 && c <= 7'h06) || (c >= 7'h0a && c <= 7'h17) ||
             (c >= 7'h1d && c <= 7'h26) || (c >= 7'h3c && c <= 7'h56);
   endfunction : is_param

   function automatic logic in_range(input logic [6:0] c, input logic [15:0] d);
      logic signed [15:0] v;
      v = $signed(d);
      unique case (c)
         7'h06: return v >= -16'sd100 && v <= 16'sd100;
         7'h10, 7'h11: return v >= 16'sd0 && v <= 16'sd6000;
         7'h1d, C_TRIM, C_RATE_THR: return v >= 16'sd0 && v <= 16'sd100;
         7'h3c: return v >= 16'sd0 && v <= 16'sd50;
         C_SCALE_PRI, C_SCALE_SEC: return v >= 16'sd0 && v <= 16'sd3;
         C_DISP_PRI, C_DISP_SEC: return v >= 16'sd1 && v <= 16'sd2;
         C_STATION: return v >= 16'sd1 && v <= 16'sd32;
         C_BAUD: return v >= 16'sd1 && v <= 16'sd6;
         C_FORMAT: return v >= 16'sd1 && v <= 16'sd3;
         C_CTL_MASK: return v >= 16'sd0 && v <= 16'sd255;
         C_ZS_LOGIC: return v >= 16'sd0 && v <= 16'sd1;
         C_SP_MASK: return v >= 16'sd0 && v <= 16'sd2;
         C_AOUT_SEL: return v >= 16'sd0 && v <= 16'sd99;
         7'h52, C_AIN_ZERO: return v >= 16'sd0 && v <= 16'sd2048;
         7'h53, C_AIN_SPAN: return v >= 16'sd2048 && v <= 16'sd4095;
         C_AIN_SEL: return v >= 16'sd0 && v <= 16'sd7;
         default: return v >= 16'sd0 && v <= 16'sd9999;
      endcase
   endfunction : in_range

   function automatic logic [15:0] default_of(input int c);
      unique case (c)
         5, 16, 17: return 16'h0032;
         11, 13, 14, 15, 20, 22: return 16'h07d0;
         21, 23: return 16'h03e8;
         30, 31, 32, 33, 34, 35, 36, 37, 38: return 16'h0001;
         63, 64, 70, 72: return 16'h0001;
         68: return TRIM_FULL;
         71: return 16'h0006;
         83, 86: return 16'h0800;
         default: return 16'h0000;
      endcase
   endfunction : default_of

   function automatic logic [15:0] value_of(input logic [6:0] c);
      unique case (c)
         C_FW_SUFFIX: return FW_SUFFIX_VAL;          // [RULE22]
         C_FW_REV: return FW_REV_VAL;                // [RULE22]
         C_FEEDBACK: return feedback_frequency;
         C_RAMPED: return ramped_reference;
         C_PULSE_ERR: return pulse_err_reg;
         C_AIN_RAW: return {4'h0, ain_filt_reg};     // [RULE21]
         C_AIN_ADJ: return {4'h0, ain_adj_reg};      // [RULE21]
         C_LINE_DIP: return line_dip_counter_reg;
         C_SER_ERR: return {10'h000, serial_error_code_reg};
         C_FREQ_OVF: return freq_overflow_counter_reg;
         default: return is_param(c) ? param_mem[c] : 16'h0000;
      endcase
   endfunction : value_of

   // Station match and error evaluation for an incoming host message.
   always_comb begin
      addressed = msg.valid && (msg.station == STATION_ALL ||            // [RULE11]
                  msg.station == param_mem[C_STATION][5:0]);             // [RULE10]
      msg_range_ok = !msg.write || !is_param(msg.code) || in_range(msg.code, msg.data);
      msg_err_next = msg.link_err;                                       // [RULE3]
      if (msg.write && !is_param(msg.code)) begin
         msg_err_next = msg_err_next | SE_CODE;
      end
      if (!computer_mode) begin
         msg_err_next = msg_err_next | SE_LOCAL;
      end
      if (!msg_range_ok) begin
         msg_err_next = msg_err_next | SE_RANGE;                          // [RULE25]
      end
   end

   // Parameter store; a host write lands after a keypad write in the same cycle.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int i = 0; i < 128; i++) begin
            param_mem[i] <= default_of(i);
         end
      end else begin
         if (wr && is_param(addr) && in_range(addr, wdata)) begin        // [RULE25]
            param_mem[addr] <= wdata;
         end
         if (addressed && msg.write && msg_err_next == 6'h00) begin
            param_mem[msg.code] <= msg.data;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         serial_error_code_reg <= 6'h00;
         msg_accept <= 1'b0;
      end else begin
         msg_accept <= addressed;
         if (addressed) begin
            serial_error_code_reg <= msg_err_next;                        // [RULE4]
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         rdata <= value_of(addr);
      end else begin
         rdata <= 16'h0000;
      end
   end

   // Event counters: an event in the clearing cycle still counts.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         line_dip_counter_reg <= 16'h0000;
      end else if (clear_key && keypad_code == C_LINE_DIP) begin         // [RULE1]
         line_dip_counter_reg <= {15'h0000, line_dip};
      end else if (line_dip && line_dip_counter_reg != DPS_CNT_MAX) begin // [RULE24]
         line_dip_counter_reg <= line_dip_counter_reg + 16'h0001;        // [RULE1]
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         freq_overflow_counter_reg <= 16'h0000;
      end else if (clear_key && keypad_code == C_FREQ_OVF) begin        // [RULE2]
         freq_overflow_counter_reg <= {15'h0000, freq_overflow};
      end else if (freq_overflow && freq_overflow_counter_reg != DPS_CNT_MAX) begin // [RULE24]
         freq_overflow_counter_reg <= freq_overflow_counter_reg + 16'h0001; // [RULE2]
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pulse_err_reg <= 16'sh0000;
         stop_prev_reg <= 1'b0;
      end else begin
         stop_prev_reg <= stop_state;
         if (stop_state && !stop_prev_reg) begin
            pulse_err_reg <= 16'sh0000;                                   // [RULE23]
         end else if (ref_pulse && !fb_pulse) begin
            pulse_err_reg <= pulse_err_reg + 16'sh0001;
         end else if (fb_pulse && !ref_pulse) begin
            pulse_err_reg <= pulse_err_reg - 16'sh0001;
         end
      end
   end

   // Mode selects, PID term gating and trim split.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         scale_mode <= 2'h0;
         display_mode <= 2'h1;
         pid_term_en <= 3'h0;
         rate_active <= 1'b0;
         pid_share <= 7'h64;
         ff_share <= 7'h00;
      end else begin
         scale_mode <= secondary_sel ? param_mem[C_SCALE_SEC][1:0] :
                       param_mem[C_SCALE_PRI][1:0];                      // [RULE5]
         display_mode <= secondary_sel ? param_mem[C_DISP_SEC][1:0] :
                         param_mem[C_DISP_PRI][1:0];                     // [RULE6]
         pid_term_en <= {param_mem[C_RATE] != 16'h0000, param_mem[C_RESET] != 16'h0000,
                         param_mem[C_GAIN] != 16'h0000};                 // [RULE7]
         rate_active <= param_mem[C_RATE] != 16'h0000 &&
                        diff_error >= param_mem[C_RATE_THR];             // [RULE8]
         pid_share <= param_mem[C_TRIM][6:0];                             // [RULE9]
         ff_share <= 7'(TRIM_FULL - param_mem[C_TRIM]);                   // [RULE9]
      end
   end

   // Bit-rate enable and character frame.
   always_comb begin
      baud_div_next = 18'(CLK_HZ / BAUD_RATE[5]);
      for (int i = 0; i < 6; i++) begin
         if (param_mem[C_BAUD] == 16'(i + 1)) begin
            baud_div_next = 18'(CLK_HZ / BAUD_RATE[i]);                   // [RULE12]
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         baud_cnt_reg <= 18'h00000;
         bit_tick <= 1'b0;
         frame <= '{eight_bits: 1'b1, even_parity: 1'b0, two_stops: 1'b0};
      end else begin
         bit_tick <= baud_cnt_reg >= baud_div_next - 18'h00001;
         baud_cnt_reg <= (baud_cnt_reg >= baud_div_next - 18'h00001) ? 18'h00000 :
                         baud_cnt_reg + 18'h00001;
         frame.eight_bits <= param_mem[C_FORMAT] != 16'h0002;              // [RULE13]
         frame.even_parity <= param_mem[C_FORMAT] == 16'h0002;             // [RULE13]
         frame.two_stops <= param_mem[C_FORMAT] == 16'h0003;               // [RULE13]
      end
   end

   // Switch delegation, zero-speed output and setpoint lockout.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctl_effective <= 8'h00;
         zero_speed <= 1'b0;
         setpoint_edit_en <= 4'hf;
      end else begin
         ctl_effective <= computer_mode ?
            ((host_ctl & param_mem[C_CTL_MASK][7:0]) |
             (switch_ctl & ~param_mem[C_CTL_MASK][7:0])) : switch_ctl;    // [RULE14]
         if (ramped_reference != 16'h0000) begin
            zero_speed <= 1'b0;                                            // [RULE15]
         end else if (param_mem[C_ZS_LOGIC][0] == 1'b0) begin
            zero_speed <= 1'b1;                                            // [RULE15]
         end else if (feedback_frequency == 16'h0000) begin
            zero_speed <= 1'b1;                                            // [RULE16]
         end
         if (!keypad_lockout) begin
            setpoint_edit_en <= 4'hf;
         end else begin
            unique case (param_mem[C_SP_MASK][1:0])
               2'h1: setpoint_edit_en <= 4'h0;                             // [RULE17]
               2'h2: setpoint_edit_en <= 4'h5;                             // [RULE17]
               default: setpoint_edit_en <= 4'hf;
            endcase
         end
      end
   end

   // Analog output scaling and analog input filtering and correction.
   logic [15:0] aout_src;
   logic [27:0] aout_prod;
   logic [11:0] ain_above_zero;
   logic [23:0] ain_gain;
   always_comb begin
      aout_src = value_of(param_mem[C_AOUT_SEL][6:0]);                    // [RULE18]
      aout_prod = 28'(aout_src) * 28'(AOUT_FULL);
      ain_above_zero = (ain_filt_reg > param_mem[C_AIN_ZERO][11:0]) ?
                       ain_filt_reg - param_mem[C_AIN_ZERO][11:0] : 12'h000;
      ain_gain = 24'(ain_above_zero) * 24'(param_mem[C_AIN_SPAN][11:0]);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         aout_level <= 12'h000;
         ain_filt_reg <= 12'h000;
         ain_adj_reg <= 12'h000;
         ain_replace <= 7'h00;
      end else begin
         if (param_mem[C_AOUT_FS] == 16'h0000) begin
            aout_level <= 12'h000;
         end else if (aout_src >= param_mem[C_AOUT_FS]) begin
            aout_level <= AOUT_FULL;                                        // [RULE19]
         end else begin
            aout_level <= 12'(aout_prod / 28'(param_mem[C_AOUT_FS]));      // [RULE19]
         end
         ain_filt_reg <= 12'($signed({1'b0, ain_filt_reg}) +
            ($signed({1'b0, ain_sample} - {1'b0, ain_filt_reg}) >>> AIN_FILT_SHIFT));
         ain_adj_reg <= (ain_gain[23:AIN_SPAN_SHIFT] > 13'(AOUT_FULL)) ? AOUT_FULL :
                        ain_gain[22:AIN_SPAN_SHIFT];                        // [RULE21]
         for (int i = 0; i < 7; i++) begin
            ain_replace[i] <= param_mem[C_AIN_SEL] == 16'(i + 1);           // [RULE20]
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   property p_dip_count;
      line_dip && !clear_key && line_dip_counter_reg < DPS_CNT_MAX
         |=> line_dip_counter_reg == $past(line_dip_counter_reg) + 16'h0001;
   endproperty
   a_dip_count: assert property (p_dip_count) else $error("dip count missed"); // [RULE1]
   property p_ovf_clear;
      clear_key && keypad_code == C_FREQ_OVF && !freq_overflow |=> freq_overflow_counter_reg == 0;
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared"); // [RULE2]
   property p_err_follow;
      addressed |=> serial_error_code_reg == $past(msg_err_next) && msg_accept;
   endproperty
   a_err_follow: assert property (p_err_follow) else $error("error code stale"); // [RULE4]
   property p_global;
      msg.valid && msg.station == STATION_ALL |=> msg_accept;
   endproperty
   a_global: assert property (p_global) else $error("global message refused"); // [RULE11]
   property p_zs0;
      param_mem[C_ZS_LOGIC] == 16'h0000 && ramped_reference == 16'h0000 ##1
      param_mem[C_ZS_LOGIC] == 16'h0000 |-> zero_speed;
   endproperty
   a_zs0: assert property (p_zs0) else $error("zero speed not high"); // [RULE15]
   property p_zs1;
      ramped_reference != 16'h0000 |=> !zero_speed;
   endproperty
   a_zs1: assert property (p_zs1) else $error("zero speed high with motion"); // [RULE15]
   property p_stop_clear;
      $rose(stop_state) |=> pulse_err_reg == 16'sh0000;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("pulse error kept"); // [RULE23]
   property p_sat;
      line_dip_counter_reg == DPS_CNT_MAX && !clear_key |=> line_dip_counter_reg == DPS_CNT_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("counter wrapped"); // [RULE24]
   property p_range;
      addressed && !msg_range_ok |=> serial_error_code_reg[5];
   endproperty
   a_range: assert property (p_range) else $error("range bit missing"); // [RULE25]
   c_msg: cover property (addressed && msg.write && msg_err_next == 6'h00);
   c_zs_latch: cover property (param_mem[C_ZS_LOGIC] == 16'h0001 && $rose(zero_speed));
   c_sat: cover property (line_dip_counter_reg == DPS_CNT_MAX);
endmodule : dps_bank
`default_nettype wire

// ==== verification/dps_host_model.sv ====
// Host computer model that sends framed messages to the bank.
`timescale 1ns/100ps
`default_nettype none
module dps_host_model import dps_pkg::*; (
   input wire logic mclk,
   output dps_msg_t msg
);
   // Host link settings match the bank defaults.
   localparam int HOST_BAUD = 6;
   localparam int HOST_FMT = 1;
   initial msg = '0;
   // Idle fields other than link_err show inverted values so stale data cannot pass.
   task automatic send(input logic w, input logic [5:0] st, input logic [6:0] c,
         input logic [15:0] d, input logic [5:0] le);
      @(posedge mclk);
      msg <= '{1'b1, w, st, c, d, le};
      @(posedge mclk);
      msg <= '{1'b0, ~w, ~st, ~c, ~d, 6'h00};
   endtask : send
endmodule : dps_host_model
`default_nettype wire

// ==== verification/dps_bank_tb_top.sv ====
// Self-checking testbench for the drive parameter and status bank.
`timescale 1ns/100ps
`default_nettype none
module dps_bank_tb_top import dps_pkg::*;;
   logic mclk, nrst, wr, rd, cm, ssel, ldip, fovf, clr, rp, fp, stp, lock, acc, rate, tick, zs;
   logic [6:0] addr, kcode, ainr, pids, ffs;
   logic [15:0] wdata, rdata, rr, fb, derr, v;
   logic [7:0] swc, hc, ctl;
   logic [11:0] ains, aout;
   logic [1:0] smode, dmode;
   logic [2:0] pen;
   logic [3:0] spen;
   dps_msg_t msg;
   dps_frame_t frame;
   int err_count, checks, i, n;
   // Event strobes, bit 0 up: line dip, overflow, clear key, ref pulse, feedback pulse.
   logic [4:0] ev;
   assign {fp, rp, clr, fovf, ldip} = ev;
   dps_host_model host (.mclk(mclk), .msg(msg));
   dps_bank #(.CLK_HZ(96000)) dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .msg(msg), .computer_mode(cm), .secondary_sel(ssel),
      .line_dip(ldip), .freq_overflow(fovf), .clear_key(clr), .keypad_code(kcode),
      .ramped_reference(rr), .feedback_frequency(fb), .ref_pulse(rp), .fb_pulse(fp),
      .stop_state(stp), .diff_error(derr), .switch_ctl(swc), .host_ctl(hc),
      .keypad_lockout(lock), .ain_sample(ains), .msg_accept(acc), .scale_mode(smode),
      .display_mode(dmode), .pid_term_en(pen), .rate_active(rate), .pid_share(pids),
      .ff_share(ffs), .bit_tick(tick), .frame(frame), .ctl_effective(ctl), .zero_speed(zs),
      .setpoint_edit_en(spen), .aout_level(aout), .ain_replace(ainr));
   always #10 mclk = ~mclk;
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [6:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask : settle
   task automatic pulse(input int s, input int k);
      repeat (k) begin
         @(posedge mclk);
         ev[s] <= 1'b1;
         @(posedge mclk);
         ev[s] <= 1'b0;
      end
      settle();
   endtask : pulse
   task automatic t_reset;
      rd_reg(C_STATION); chk("station", 16'h0001, v);
      rd_reg(C_FW_SUFFIX); chk("suffix", FW_SUFFIX_VAL, v);
      rd_reg(C_FW_REV); chk("revision", FW_REV_VAL, v);
      chk("shares", 16'h6400, {1'b0, pids, 1'b0, ffs});
      wr_reg(C_STATION, 16'h0021); rd_reg(C_STATION); chk("range", 16'h0001, v);
      wr_reg(C_STATION, 16'h0005); rd_reg(C_STATION); chk("station", 16'h0005, v);
   endtask : t_reset
   task automatic t_host;
      host.send(1, 6'h07, C_SCALE_PRI, 16'h0001, 6'h00); #1 chk("refused", 16'h0, acc);
      host.send(1, 6'h00, C_SCALE_PRI, 16'h0002, 6'h00); #1 chk("all", 16'h1, acc);
      settle(); chk("scale", 16'h0002, smode);
      host.send(1, 6'h05, C_SCALE_PRI, 16'h0004, 6'h02);
      rd_reg(C_SER_ERR); chk("ser err", 16'h0022, v);
      host.send(1, 6'h05, C_LINE_DIP, 16'h0001, 6'h00);
      rd_reg(C_SER_ERR); chk("ser err", 16'h0010, v);
      cm <= 1'b0; host.send(0, 6'h05, C_STATION, 16'h0, 6'h08);
      rd_reg(C_SER_ERR); chk("ser err", 16'h0009, v);
      cm <= 1'b1;
   endtask : t_host
   task automatic t_events;
      pulse(0, 3); rd_reg(C_LINE_DIP); chk("dips", 16'h0003, v);
      kcode <= C_LINE_DIP; pulse(2, 1); rd_reg(C_LINE_DIP); chk("dips", 16'h0, v);
      // A dip input held 10010 cycles counts every cycle until it saturates at DPS_CNT_MAX.
      @(posedge mclk);
      ev[0] <= 1'b1;
      repeat (10010) @(posedge mclk);
      ev[0] <= 1'b0;
      settle();
      rd_reg(C_LINE_DIP);
      chk("dips", DPS_CNT_MAX, v);
      pulse(1, 2); rd_reg(C_FREQ_OVF); chk("ovf", 16'h0002, v);
      kcode <= C_FREQ_OVF; pulse(2, 1); rd_reg(C_FREQ_OVF); chk("ovf", 16'h0, v);
      pulse(3, 3); pulse(4, 1); rd_reg(C_PULSE_ERR); chk("perr", 16'h0002, v);
      stp <= 1'b1; settle(); rd_reg(C_PULSE_ERR); chk("perr", 16'h0, v);
   endtask : t_events
   task automatic t_zero;
      rr <= 16'h5; fb <= 16'h5; settle(); chk("zs", 16'h0, zs);
      rr <= 16'h0; settle(); chk("zs", 16'h1, zs);
      wr_reg(C_ZS_LOGIC, 16'h1); rr <= 16'h5; settle(); chk("zs", 16'h0, zs);
      rr <= 16'h0; settle(); chk("zs", 16'h0, zs);
      fb <= 16'h0; settle(); fb <= 16'h9; settle(); chk("zs", 16'h1, zs);
      rr <= 16'h5; settle(); chk("zs", 16'h0, zs);
   endtask : t_zero
   task automatic t_params;
      wr_reg(C_SCALE_SEC, 16'h3); wr_reg(C_DISP_SEC, 16'h2); ssel <= 1'b1; settle();
      chk("modes", 16'h0032, {smode, 2'b00, dmode});
      wr_reg(C_GAIN, 16'h5); wr_reg(C_RESET, 16'h0); wr_reg(C_RATE, 16'h7);
      wr_reg(C_RATE_THR, 16'ha); wr_reg(C_TRIM, 16'h1e); derr <= 16'h9; settle();
      chk("terms", 16'h0005, pen); chk("rate", 16'h0, rate);
      chk("shares", 16'h1e46, {1'b0, pids, 1'b0, ffs});
      derr <= 16'ha; settle(); chk("rate", 16'h1, rate);
      hc <= 8'h04; wr_reg(C_CTL_MASK, 16'h24); settle(); chk("ctl", 16'h00df, ctl);
      wr_reg(C_AOUT_SEL, {9'h000, C_STATION}); wr_reg(C_AOUT_FS, 16'ha); settle();
      chk("aout", 16'h07ff, aout);
      lock <= 1'b1;
      for (i = 0; i < 3; i++) begin
         wr_reg(C_SP_MASK, 16'(i));
         settle();
         chk("spmask", i == 0 ? 4'hf : 4'h5 * (i - 1), spen);
      end
      for (i = 0; i < 8; i++) begin
         wr_reg(C_AIN_SEL, 16'(i));
         settle();
         chk("ain", i == 0 ? 0 : 7'h1 << (i - 1), ainr);
      end
      for (i = 1; i < 4; i++) begin
         wr_reg(C_FORMAT, 16'(i));
         settle();
         chk("frame", i == 1 ? 4 : i == 2 ? 2 : 5, frame);
      end
      for (i = 1; i < 7; i++) begin
         wr_reg(C_BAUD, 16'(i)); settle(); n = 0;
         while (tick !== 1'b1 && n < 400) begin @(posedge mclk); #1 n++; end
         n = 0;
         do begin @(posedge mclk); #1 n++; end while (tick !== 1'b1 && n < 400);
         chk("bit period", 96000 / BAUD_RATE[i - 1], n);
      end
   endtask : t_params
   task automatic summarize;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      {mclk, nrst, wr, rd, ev, stp, lock, ssel} = '0;
      {addr, kcode, wdata, rr, fb, derr, ains} = '0;
      cm = 1'b1; swc = 8'hff; hc = 8'h00;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      t_reset(); t_host(); t_events(); t_zero(); t_params();
      summarize();
   end
   initial begin
      #600000;
      err_count++;
      summarize();
   end
endmodule : dps_bank_tb_top
`default_nettype wire
